// File: hw/msd_regs.svh
// Constants for the memory-space decode core: widths, region bounds,
// core I/O locations, flag positions and program-memory sectioning.
// Assumes it is included by the package and nowhere else.
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH

`define MSD_PW            23
`define MSD_DW            24

// Data-space regions, byte addresses.
`define MSD_IO_DIRECT_END 24'h00_003F
`define MSD_IO_END        24'h00_0FFF
`define MSD_NVM_BASE      24'h00_1000
`define MSD_NVM_END       24'h00_1FFF
`define MSD_SRAM_BASE     24'h00_2000
`define MSD_SRAM_END      24'h00_3FFF

// Core registers reached through the direct I/O instructions.
`define MSD_IO_RAMPX      6'h39
`define MSD_IO_RAMPY      6'h3A
`define MSD_IO_RAMPZ      6'h3B
`define MSD_IO_SREG       6'h3F

// Status flag positions.
`define MSD_FLAG_C        0
`define MSD_FLAG_Z        1
`define MSD_FLAG_N        2
`define MSD_FLAG_V        3
`define MSD_FLAG_S        4
`define MSD_FLAG_H        5

// Lock field: bit 0 blocks writes, bit 1 blocks reads and writes.
`define MSD_LOCK_WP       0
`define MSD_LOCK_RP       1

// Program memory sections, word addresses.
`define MSD_TBL_START     23'h00_7800
`define MSD_BOOT_START    23'h00_8000

// Pointer register indices in the register file.
`define MSD_XL            5'h1A
`define MSD_XH            5'h1B
`define MSD_YL            5'h1C
`define MSD_YH            5'h1D
`define MSD_ZL            5'h1E
`define MSD_ZH            5'h1F

`endif

// File: hw/msd_pkg.sv
// Types, state codes and the flag arithmetic of the memory-space core.
// Assumes msd_regs.svh is on the include path.
`include "msd_regs.svh"
`default_nettype none

package msd_pkg;

    typedef logic [`MSD_PW-1:0] msd_paddr_t;
    typedef logic [`MSD_DW-1:0] msd_daddr_t;
    typedef logic [7:0]         msd_byte_t;
    typedef logic [15:0]        msd_word_t;
    typedef logic [1:0]         msd_lock_t;

    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_ADD  = 4'h1,
        OP_SUB  = 4'h2,
        OP_LDI  = 4'h3,
        OP_IN   = 4'h4,
        OP_OUT  = 4'h5,
        OP_LD   = 4'h6,
        OP_ST   = 4'h7,
        OP_LPM  = 4'h8,
        OP_SPM  = 4'h9,
        OP_RJMP = 4'hA
    } msd_op_t;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_DATA     = 3'b001,
        ST_LPM_WAIT = 3'b010,
        ST_LPM_TAKE = 3'b011,
        ST_SPM_WR   = 3'b100
    } msd_state_t;

    typedef enum logic [1:0] {
        SECT_APP   = 2'b00,
        SECT_TABLE = 2'b01,
        SECT_BOOT  = 2'b10
    } msd_sect_t;

    // Returns {flags[5:0], result[7:0]} for an 8-bit add or subtract.
    function automatic logic [13:0] msd_addsub(input msd_byte_t a,
                                               input msd_byte_t b,
                                               input logic      sub);
        logic [8:0] s;
        logic [4:0] h;
        logic       v;
        logic [5:0] f;
        if (sub) begin
            s = {1'b0, a} - {1'b0, b};
            h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
            v = (a[7] ^ b[7]) & (a[7] ^ s[7]);
        end else begin
            s = {1'b0, a} + {1'b0, b};
            h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            v = ~(a[7] ^ b[7]) & (a[7] ^ s[7]);
        end
        f[`MSD_FLAG_C] = s[8];
        f[`MSD_FLAG_Z] = (s[7:0] == 8'h00);
        f[`MSD_FLAG_N] = s[7];
        f[`MSD_FLAG_V] = v;
        f[`MSD_FLAG_S] = s[7] ^ v;
        f[`MSD_FLAG_H] = h[4];
        return {f, s[7:0]};
    endfunction

endpackage

`default_nettype wire

// File: hw/msd_data_decode.sv
// Data-space region decoder: one select per byte address, combinational.
// Assumes the caller registers the selects before they leave the block.
`default_nettype none

module msd_data_decode
    import msd_pkg::*;
(
    input  wire msd_pkg::msd_daddr_t addr_i,      // Data byte address.
    output logic                     sel_io_o,    // I/O region.
    output logic                     io_ext_o,    // Extended I/O part.
    output logic                     sel_nvm_o,   // Nonvolatile window.
    output logic                     sel_sram_o,  // Internal SRAM.
    output logic                     sel_ext_o    // External RAM.
);

    always_comb begin
        sel_io_o   = 1'b0;
        sel_nvm_o  = 1'b0;
        sel_sram_o = 1'b0;
        sel_ext_o  = 1'b0;
        if (addr_i <= `MSD_IO_END) begin
            sel_io_o = 1'b1;
        end else if (addr_i <= `MSD_NVM_END) begin
            sel_nvm_o = 1'b1;
        end else if (addr_i <= `MSD_SRAM_END) begin
            sel_sram_o = 1'b1;
        end else begin
            sel_ext_o = 1'b1;
        end
        io_ext_o = sel_io_o && (addr_i > `MSD_IO_DIRECT_END);
    end

endmodule

`default_nettype wire

// File: hw/msd_core.sv
// Memory-space front end of a small 8-bit core: prefetching fetch unit,
// register file, pointers, data-space access and program memory guards.
// Assumes a program memory with one cycle read latency and a data side
// whose read data is valid in the cycle the read strobe is high, all on
// ref_clk_i. Lock inputs come from same-clock nonvolatile logic.
//
// Notes on behaviour
// - Program and data use separate buses, usable in the same cycle.
// - Next instruction is fetched while the current one executes.
// - Thirty-two 8-bit registers, each read and written in one cycle.
// - Three register pairs serve as 16-bit data pointers; only Z also points into program memory.
// - Status flags follow every arithmetic result.
// - All peripheral registers lie in the lowest 4KB of data space.
// - Addresses 0x00..0x3F reachable by I/O and data-space accesses; at 0x39..0x3B and 0x3F I/O reaches core registers instead.
// - 0x0040..0x0FFF only through data-space loads and stores.
// - 0x1000..0x1FFF is the nonvolatile data memory window.
// - SRAM starts at 0x2000; above it lies external RAM.
// - Instructions come only from program memory, never from SRAM.
// - Extension bytes widen pointers to reach 16MB in each space.
// - Multi-byte peripheral accesses happen as one locked burst.
// - Application and boot sections each have write and read locks.
// - Self-programming works only when issued from the boot section.
// - Application table section has its own write and read locks.
// - After reset the first fetch is from program address zero.
`default_nettype none

module msd_core
    import msd_pkg::*;
(
    input  wire logic                ref_clk_i,     // Core clock.
    input  wire logic                rst_i,         // Async reset, high.
    output msd_pkg::msd_paddr_t      pmem_addr_o,   // Program word addr.
    input  wire msd_pkg::msd_word_t  pmem_rdata_i,  // Program read word.
    output logic                     pmem_we_o,     // Program write.
    output msd_pkg::msd_word_t       pmem_wdata_o,  // Program write word.
    output msd_pkg::msd_daddr_t      dmem_addr_o,   // Data byte address.
    output msd_pkg::msd_byte_t       dmem_wdata_o,  // Data write byte.
    input  wire msd_pkg::msd_byte_t  dmem_rdata_i,  // Data read byte.
    output logic                     dmem_re_o,     // Data read strobe.
    output logic                     dmem_we_o,     // Data write strobe.
    output logic                     dmem_lock_o,   // Burst in progress.
    output logic                     sel_io_o,      // I/O region.
    output logic                     sel_ioext_o,   // Extended I/O.
    output logic                     sel_nvm_o,     // NVM window.
    output logic                     sel_sram_o,    // Internal SRAM.
    output logic                     sel_ext_o,     // External RAM.
    input  wire msd_pkg::msd_lock_t  lock_app_i,    // Application locks.
    input  wire msd_pkg::msd_lock_t  lock_tbl_i,    // Table locks.
    input  wire msd_pkg::msd_lock_t  lock_boot_i,   // Boot locks.
    output msd_pkg::msd_byte_t       sreg_o,        // Status flags.
    output logic                     prot_fault_o   // Blocked access.
);

    import msd_pkg::*;

    msd_state_t state_q;
    logic       ivalid_q;
    msd_paddr_t pmem_addr_q;
    msd_paddr_t exec_pc_q;
    msd_paddr_t ret_pc_q;
    logic       pmem_we_q;
    msd_word_t  pmem_wdata_q;
    msd_byte_t  rf_q [32];
    msd_byte_t  sreg_q;
    msd_byte_t  ramp_x_q;
    msd_byte_t  ramp_y_q;
    msd_byte_t  ramp_z_q;
    msd_daddr_t acc_base_q;
    logic [1:0] acc_idx_q;
    logic [1:0] acc_nbm1_q;
    logic [4:0] acc_rd_q;
    logic       acc_load_q;
    msd_daddr_t dmem_addr_q;
    msd_byte_t  dmem_wdata_q;
    logic       dmem_re_q;
    logic       dmem_we_q;
    logic       dmem_lock_q;
    logic       sel_io_q;
    logic       sel_ioext_q;
    logic       sel_nvm_q;
    logic       sel_sram_q;
    logic       sel_ext_q;
    logic       lpm_hi_q;
    logic       lpm_deny_q;
    logic       prot_fault_q;

    msd_word_t  instr;
    msd_op_t    op;
    logic       exec;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] io_a;
    logic [1:0] nbm1;
    logic       core_io;
    msd_byte_t  core_rd;
    msd_daddr_t ptr_x;
    msd_daddr_t ptr_y;
    msd_daddr_t ptr_z;
    msd_daddr_t ptr_sel;
    msd_paddr_t z_word;
    msd_paddr_t next_pc;
    logic       start_acc;
    logic       acc_load;
    msd_daddr_t acc_base;
    logic       acc_last;
    logic [1:0] idx_nx;
    msd_daddr_t acc_addr_d;
    logic       addr_ld;
    logic [13:0] alu;
    msd_sect_t  sect_exec;
    msd_sect_t  sect_tgt;
    msd_lock_t  lock_tgt;
    logic       lpm_deny;
    logic       spm_ok;
    logic       rf_we;
    logic [4:0] rf_wa;
    msd_byte_t  rf_wd;
    logic       dec_io;
    logic       dec_ioext;
    logic       dec_nvm;
    logic       dec_sram;
    logic       dec_ext;

    function automatic msd_sect_t sect_of(input msd_paddr_t a);
        if (a >= `MSD_BOOT_START) begin
            return SECT_BOOT;
        end
        if (a >= `MSD_TBL_START) begin
            return SECT_TABLE;
        end
        return SECT_APP;
    endfunction

    function automatic logic is_core_io(input logic [5:0] a);
        return (a == `MSD_IO_RAMPX) || (a == `MSD_IO_RAMPY) ||
               (a == `MSD_IO_RAMPZ) || (a == `MSD_IO_SREG);
    endfunction

    assign instr   = pmem_rdata_i;
    assign op      = msd_op_t'(instr[15:12]);
    assign exec    = (state_q == ST_RUN) && ivalid_q;
    assign rd      = instr[4:0];
    assign rr      = instr[9:5];
    assign io_a    = instr[10:5];
    // A count code of three would overrun 24 bits, so it acts as two (three bytes).
    assign nbm1    = (instr[8:7] == 2'b11) ? 2'b10 : instr[8:7];
    assign core_io = is_core_io(io_a);
    assign next_pc = exec_pc_q + 1'b1;

    always_comb begin
        unique case (io_a)
            `MSD_IO_RAMPX: core_rd = ramp_x_q;
            `MSD_IO_RAMPY: core_rd = ramp_y_q;
            `MSD_IO_RAMPZ: core_rd = ramp_z_q;
            default:       core_rd = sreg_q;
        endcase
    end

    assign ptr_x  = {ramp_x_q, rf_q[`MSD_XH], rf_q[`MSD_XL]};
    assign ptr_y  = {ramp_y_q, rf_q[`MSD_YH], rf_q[`MSD_YL]};
    assign ptr_z  = {ramp_z_q, rf_q[`MSD_ZH], rf_q[`MSD_ZL]};
    assign z_word = ptr_z[`MSD_DW-1:1];

    always_comb begin
        unique case (instr[6:5])
            2'b00:   ptr_sel = ptr_x;
            2'b01:   ptr_sel = ptr_y;
            default: ptr_sel = ptr_z;
        endcase
    end

    always_comb begin
        start_acc = 1'b0;
        acc_load  = 1'b0;
        acc_base  = {18'h0_0000, io_a};
        case (op)
            OP_LD: begin
                start_acc = 1'b1;
                acc_load  = 1'b1;
                acc_base  = ptr_sel;
            end
            OP_ST: begin
                start_acc = 1'b1;
                acc_base  = ptr_sel;
            end
            OP_IN: begin
                start_acc = !core_io;
                acc_load  = 1'b1;
            end
            OP_OUT:  start_acc = !core_io;
            default: start_acc = 1'b0;
        endcase
    end

    assign acc_last   = (acc_idx_q == acc_nbm1_q);
    assign idx_nx     = acc_idx_q + 1'b1;
    assign acc_addr_d = (state_q == ST_DATA) ?
                        acc_base_q + {22'h00_0000, idx_nx} : acc_base;
    assign addr_ld    = (exec && start_acc) ||
                        (state_q == ST_DATA && !acc_last);

    msd_data_decode u_decode (
        .addr_i     (acc_addr_d),
        .sel_io_o   (dec_io),
        .io_ext_o   (dec_ioext),
        .sel_nvm_o  (dec_nvm),
        .sel_sram_o (dec_sram),
        .sel_ext_o  (dec_ext)
    );

    assign sect_exec = sect_of(exec_pc_q);
    assign sect_tgt  = sect_of(z_word);
    always_comb begin
        unique case (sect_tgt)
            SECT_BOOT:  lock_tgt = lock_boot_i;
            SECT_TABLE: lock_tgt = lock_tbl_i;
            default:    lock_tgt = lock_app_i;
        endcase
    end
    assign lpm_deny = lock_tgt[`MSD_LOCK_RP] && (sect_tgt != sect_exec);
    assign spm_ok   = (sect_exec == SECT_BOOT) &&
                      !lock_tgt[`MSD_LOCK_WP] && !lock_tgt[`MSD_LOCK_RP];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q      <= ST_RUN;
            ivalid_q     <= 1'b0;
            pmem_addr_q  <= '0;
            exec_pc_q    <= '0;
            ret_pc_q     <= '0;
            pmem_we_q    <= 1'b0;
            pmem_wdata_q <= '0;
        end else begin
            exec_pc_q <= pmem_addr_q;
            pmem_we_q <= 1'b0;
            unique case (state_q)
                ST_RUN: begin
                    ivalid_q    <= 1'b1;
                    pmem_addr_q <= pmem_addr_q + 1'b1;
                    if (exec) begin
                        ret_pc_q <= next_pc;
                        if (start_acc) begin
                            state_q     <= ST_DATA;
                            ivalid_q    <= 1'b0;
                            pmem_addr_q <= next_pc;
                        end else if (op == OP_LPM) begin
                            state_q     <= ST_LPM_WAIT;
                            ivalid_q    <= 1'b0;
                            pmem_addr_q <= z_word;
                        end else if (op == OP_SPM) begin
                            state_q      <= ST_SPM_WR;
                            ivalid_q     <= 1'b0;
                            pmem_addr_q  <= z_word;
                            pmem_we_q    <= spm_ok;
                            pmem_wdata_q <= {rf_q[1], rf_q[0]};
                        end else if (op == OP_RJMP) begin
                            ivalid_q    <= 1'b0;
                            pmem_addr_q <= next_pc +
                                           {{11{instr[11]}}, instr[11:0]};
                        end
                    end
                end
                ST_DATA: begin
                    if (acc_last) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_LPM_WAIT: state_q <= ST_LPM_TAKE;
                ST_LPM_TAKE: begin
                    state_q     <= ST_RUN;
                    pmem_addr_q <= ret_pc_q;
                end
                ST_SPM_WR: begin
                    state_q     <= ST_RUN;
                    pmem_addr_q <= ret_pc_q;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_base_q   <= '0;
            acc_idx_q    <= 2'h0;
            acc_nbm1_q   <= 2'h0;
            acc_rd_q     <= 5'h00;
            acc_load_q   <= 1'b0;
            dmem_wdata_q <= 8'h00;
            dmem_re_q    <= 1'b0;
            dmem_we_q    <= 1'b0;
            dmem_lock_q  <= 1'b0;
        end else if (exec && (start_acc || op == OP_LPM)) begin
            acc_base_q   <= acc_base;
            acc_idx_q    <= 2'h0;
            acc_nbm1_q   <= (op == OP_LD || op == OP_ST) ? nbm1 : 2'h0;
            acc_rd_q     <= rd;
            acc_load_q   <= acc_load;
            dmem_wdata_q <= rf_q[rd];
            dmem_re_q    <= start_acc && acc_load;
            dmem_we_q    <= start_acc && !acc_load;
            dmem_lock_q  <= start_acc && (op == OP_LD || op == OP_ST) &&
                            (nbm1 != 2'h0);
        end else if (state_q == ST_DATA) begin
            if (acc_last) begin
                dmem_re_q   <= 1'b0;
                dmem_we_q   <= 1'b0;
                dmem_lock_q <= 1'b0;
            end else begin
                acc_idx_q    <= idx_nx;
                dmem_wdata_q <= rf_q[acc_rd_q + {3'h0, idx_nx}];
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dmem_addr_q <= '0;
            sel_io_q    <= 1'b1;
            sel_ioext_q <= 1'b0;
            sel_nvm_q   <= 1'b0;
            sel_sram_q  <= 1'b0;
            sel_ext_q   <= 1'b0;
        end else if (addr_ld) begin
            dmem_addr_q <= acc_addr_d;
            sel_io_q    <= dec_io;
            sel_ioext_q <= dec_ioext;
            sel_nvm_q   <= dec_nvm;
            sel_sram_q  <= dec_sram;
            sel_ext_q   <= dec_ext;
        end
    end

    assign alu = msd_addsub(rf_q[rd], rf_q[rr], op == OP_SUB);

    always_comb begin
        rf_we = 1'b0;
        rf_wa = rd;
        rf_wd = alu[7:0];
        if (exec) begin
            case (op)
                OP_ADD, OP_SUB: rf_we = 1'b1;
                OP_LDI: begin
                    rf_we = 1'b1;
                    rf_wa = {1'b1, instr[11:8]};
                    rf_wd = instr[7:0];
                end
                OP_IN: begin
                    rf_we = core_io;
                    rf_wd = core_rd;
                end
                default: rf_we = 1'b0;
            endcase
        end else if (state_q == ST_DATA && acc_load_q) begin
            rf_we = 1'b1;
            rf_wa = acc_rd_q + {3'h0, acc_idx_q};
            rf_wd = dmem_rdata_i;
        end else if (state_q == ST_LPM_TAKE) begin
            rf_we = 1'b1;
            rf_wa = acc_rd_q;
            rf_wd = lpm_deny_q ? 8'h00 :
                    (lpm_hi_q ? instr[15:8] : instr[7:0]);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else if (rf_we) begin
            rf_q[rf_wa] <= rf_wd;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sreg_q   <= 8'h00;
            ramp_x_q <= 8'h00;
            ramp_y_q <= 8'h00;
            ramp_z_q <= 8'h00;
        end else if (exec) begin
            if (op == OP_ADD || op == OP_SUB) begin
                sreg_q[5:0] <= alu[13:8];
            end else if (op == OP_OUT && core_io) begin
                unique case (io_a)
                    `MSD_IO_RAMPX: ramp_x_q <= rf_q[rd];
                    `MSD_IO_RAMPY: ramp_y_q <= rf_q[rd];
                    `MSD_IO_RAMPZ: ramp_z_q <= rf_q[rd];
                    default:       sreg_q   <= rf_q[rd];
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lpm_hi_q     <= 1'b0;
            lpm_deny_q   <= 1'b0;
            prot_fault_q <= 1'b0;
        end else begin
            prot_fault_q <= exec && ((op == OP_LPM && lpm_deny) ||
                                     (op == OP_SPM && !spm_ok));
            if (exec && op == OP_LPM) begin
                lpm_hi_q   <= ptr_z[0];
                lpm_deny_q <= lpm_deny;
            end
        end
    end

    assign pmem_addr_o  = pmem_addr_q;
    assign pmem_we_o    = pmem_we_q;
    assign pmem_wdata_o = pmem_wdata_q;
    assign dmem_addr_o  = dmem_addr_q;
    assign dmem_wdata_o = dmem_wdata_q;
    assign dmem_re_o    = dmem_re_q;
    assign dmem_we_o    = dmem_we_q;
    assign dmem_lock_o  = dmem_lock_q;
    assign sel_io_o     = sel_io_q;
    assign sel_ioext_o  = sel_ioext_q;
    assign sel_nvm_o    = sel_nvm_q;
    assign sel_sram_o   = sel_sram_q;
    assign sel_ext_o    = sel_ext_q;
    assign sreg_o       = sreg_q;
    assign prot_fault_o = prot_fault_q;

endmodule

`default_nettype wire

// File: sim/msd_core_props.sv
// Port-level checker for the memory-space core.
// Assumes one clock domain and the core's active high async reset.
`default_nettype none
module msd_core_props
    import msd_pkg::*;
(
    input wire logic                ref_clk_i,   // Clock.
    input wire logic                rst_i,       // Reset.
    input wire msd_pkg::msd_paddr_t pmem_addr_o, // Fetch address.
    input wire logic                pmem_we_o,   // Flash write.
    input wire msd_pkg::msd_daddr_t dmem_addr_o, // Data address.
    input wire logic                dmem_lock_o, // Burst.
    input wire logic                sel_io_o,    // I/O.
    input wire logic                sel_ioext_o, // Extended I/O.
    input wire logic                sel_nvm_o,   // NVM window.
    input wire logic                sel_sram_o,  // SRAM.
    input wire logic                sel_ext_o    // External RAM.
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_burst_step;
        dmem_lock_o ##1 dmem_lock_o;
    endsequence
    a_region_onehot: assert property (
        $onehot({sel_io_o, sel_nvm_o, sel_sram_o, sel_ext_o}))
        else $error("region selects not one-hot");
    a_io_window: assert property (
        sel_io_o == (dmem_addr_o <= 24'h00_0FFF))
        else $error("I/O select wrong");
    a_ioext_split: assert property (
        sel_ioext_o == (sel_io_o && dmem_addr_o > 24'h00_003F))
        else $error("extended I/O select wrong");
    a_nvm_window: assert property (
        sel_nvm_o == (dmem_addr_o inside {[24'h00_1000:24'h00_1FFF]}))
        else $error("NVM select wrong");
    a_sram_base: assert property (
        sel_sram_o == (dmem_addr_o inside {[24'h00_2000:24'h00_3FFF]}))
        else $error("SRAM select wrong");
    a_burst_ascend: assert property (
        s_burst_step |-> dmem_addr_o == $past(dmem_addr_o) + 24'h00_0001)
        else $error("burst bytes not ascending");
    a_reset_fetch: assert property (
        $fell(rst_i) |-> pmem_addr_o == 23'h0 ##[1:2] pmem_addr_o == 23'h1)
        else $error("fetch after reset not from zero");
    a_spm_boot: assert property (
        pmem_we_o |-> $past(pmem_addr_o) > 23'h00_8000)
        else $error("flash written from outside boot");
endmodule
bind msd_core msd_core_props msd_core_props_i (
    .ref_clk_i, .rst_i, .pmem_addr_o, .pmem_we_o, .dmem_addr_o,
    .dmem_lock_o, .sel_io_o, .sel_ioext_o, .sel_nvm_o, .sel_sram_o,
    .sel_ext_o);
`default_nettype wire

// File: sim/msd_mem_model.sv
// Program and data memory model facing the core.
// Keeps only the low 64K of each space; higher addresses wrap onto it.
`default_nettype none
module msd_mem_model
    import msd_pkg::*;
(
    input  wire logic                ref_clk_i,    // Clock.
    input  wire msd_pkg::msd_paddr_t pmem_addr_i,  // Word address.
    input  wire logic                pmem_we_i,    // Word write.
    input  wire msd_pkg::msd_word_t  pmem_wdata_i, // Write word.
    output msd_pkg::msd_word_t       pmem_rdata_o, // Read word.
    input  wire msd_pkg::msd_daddr_t dmem_addr_i,  // Byte address.
    input  wire logic                dmem_re_i,    // Read strobe.
    input  wire logic                dmem_we_i,    // Write strobe.
    input  wire msd_pkg::msd_byte_t  dmem_wdata_i, // Write byte.
    output msd_pkg::msd_byte_t       dmem_rdata_o  // Read byte.
);
    msd_word_t pmem [0:65535] = '{default: 16'h0000};
    msd_byte_t dmem [0:65535] = '{default: 8'h00};
    msd_byte_t last_q = 8'h00;
    // separate buses; fetch answers one cycle late.
    always @(posedge ref_clk_i) begin
        pmem_rdata_o <= pmem[pmem_addr_i[15:0]];
        if (pmem_we_i)
            pmem[pmem_addr_i[15:0]] <= pmem_wdata_i;
        if (dmem_we_i)
            dmem[dmem_addr_i[15:0]] <= dmem_wdata_i;
        if (dmem_re_i)
            last_q <= dmem[dmem_addr_i[15:0]];
    end
    // An idle read bus shows the inverse of its last byte, never a copy.
    assign dmem_rdata_o = dmem_re_i ? dmem[dmem_addr_i[15:0]] : ~last_q;
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for msd_core; programs are poked into the model.
// Assumes a 10 MHz clock and inputs changed at the falling edge.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import msd_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    msd_lock_t  lock_app_i = 2'b00;
    msd_lock_t  lock_tbl_i = 2'b00;
    msd_lock_t  lock_boot_i = 2'b00;
    msd_paddr_t pmem_addr_o;
    msd_word_t  pmem_rdata_i, pmem_wdata_o;
    msd_daddr_t dmem_addr_o, wr_addr;
    msd_byte_t  dmem_wdata_o, dmem_rdata_i, sreg_o;
    logic       pmem_we_o, dmem_re_o, dmem_we_o, dmem_lock_o, prot_fault_o;
    logic       sel_io_o, sel_ioext_o, sel_nvm_o, sel_sram_o, sel_ext_o;
    int         errors = 0, comparisons = 0, faults = 0;
    msd_core msd_core_i (.ref_clk_i, .rst_i, .pmem_addr_o, .pmem_rdata_i,
        .pmem_we_o, .pmem_wdata_o, .dmem_addr_o, .dmem_wdata_o,
        .dmem_rdata_i, .dmem_re_o, .dmem_we_o, .dmem_lock_o, .sel_io_o,
        .sel_ioext_o, .sel_nvm_o, .sel_sram_o, .sel_ext_o, .lock_app_i,
        .lock_tbl_i, .lock_boot_i, .sreg_o, .prot_fault_o);
    msd_mem_model mem_i (.ref_clk_i, .pmem_addr_i(pmem_addr_o),
        .pmem_we_i(pmem_we_o), .pmem_wdata_i(pmem_wdata_o),
        .pmem_rdata_o(pmem_rdata_i), .dmem_addr_i(dmem_addr_o),
        .dmem_re_i(dmem_re_o), .dmem_we_i(dmem_we_o),
        .dmem_wdata_i(dmem_wdata_o), .dmem_rdata_o(dmem_rdata_i));
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (prot_fault_o === 1'b1)
            faults++;
        if (dmem_we_o === 1'b1)
            wr_addr = dmem_addr_o;
    end
    task automatic check(string what, logic [23:0] exp, logic [23:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each run ends in a self-loop so stale code beyond it never executes.
    task automatic run(msd_word_t prog[$], int n);
        foreach (prog[i])
            mem_i.pmem[i] = prog[i];
        mem_i.pmem[prog.size()] = 16'hAFFF;
        rst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        rst_i = 1'b0;
        faults = 0;
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic t_alu();
        run('{16'h307F, 16'h3101, 16'h1230, 16'h3A00, 16'h3B20, 16'h7010}, 20);
        check("status", 24'h2C, sreg_o);
        check("sum", 24'h80, mem_i.dmem[16'h2000]);
        check("sram select", 24'h1, sel_sram_o);
    endtask
    task automatic t_burst();
        mem_i.dmem[16'h0FFE] = 8'h11;
        mem_i.dmem[16'h0FFF] = 8'h22;
        mem_i.dmem[16'h1000] = 8'h33;
        run('{16'h3CFE, 16'h3D0F, 16'h6134, 16'h3A00, 16'h3B21, 16'h7114}, 30);
        for (int k = 0; k < 3; k++)
            check("burst byte", 24'(17 * (k + 1)), mem_i.dmem[8448 + k]);
        check("burst end", 24'h00_2102, wr_addr);
    endtask
    task automatic t_io();
        run('{16'h305A, 16'h50B0, 16'h3A05, 16'h3B00, 16'h6012, 16'h3102,
              16'h5731, 16'h3B20, 16'h7012}, 30);
        check("io as data", 24'h5A, mem_i.dmem[16'h2005]);
        check("wide pointer", 24'h02_2005, wr_addr);
        check("external select", 24'h1, sel_ext_o);
    endtask
    // App code is denied twice, then a jump chain reaches the boot section.
    task automatic t_prot();
        msd_word_t boot[$] = '{16'h30CD, 16'h1200, 16'h30AB, 16'h1201,
                               16'h3F20, 16'h9000, 16'hAFFF};
        lock_tbl_i = 2'b10;
        for (int k = 1; k < 16; k++)
            mem_i.pmem[k * 2048] = 16'hA7FF;
        foreach (boot[i])
            mem_i.pmem[32768 + i] = boot[i];
        run('{16'h3E00, 16'h3FF0, 16'h8005, 16'h9000, 16'hA7FB}, 150);
        check("faults", 24'(faults), 24'h2);
        check("self write", 24'hABCD, mem_i.pmem[16'h1000]);
        lock_tbl_i = 2'b00;
    endtask
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        t_alu();
        t_burst();
        t_io();
        t_prot();
        finish_test();
    end
    initial begin
        #200_000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
